// ---- src/dss_regs.vh ----
`ifndef DSS_REGS_VH
`define DSS_REGS_VH
// Step table geometry
`define DSS_STEP_COUNT 2048
`define DSS_IDX_W 11
`define DSS_CNT_W 12
`define DSS_TIME_W 16
// Duration modes
`define DSS_MODE_TABLE 2'h0
`define DSS_MODE_FIX 2'h1
`define DSS_MODE_INCR 2'h2
`define DSS_MODE_DECL 2'h3
// Completion states
`define DSS_END_OFF 2'h0
`define DSS_END_ON 2'h1
`define DSS_END_LAST 2'h2
// Repetition limits
`define DSS_CYC_W 17
`define DSS_CYC_MAX 17'h1869F
// Duration tick: one unit of step time
`define DSS_TICK_NS 1000000
`define DSS_CLK_NS 10
`endif

// ---- src/dss_step_mem.v ----
`timescale 1ns/1ns
`default_nettype none
module dss_step_mem #(
    parameter AW = 11,
    parameter DW = 17
) (
    input wire i_clk,
    input wire i_we,
    input wire [AW-1:0] i_waddr,
    input wire [DW-1:0] i_wdata,
    input wire [AW-1:0] i_raddr,
    output reg [DW-1:0] o_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule
`default_nettype wire

// ---- src/dss_sequencer.v ----
`timescale 1ns/1ns
`default_nettype none
`include "dss_regs.vh"
module dss_sequencer #(
    parameter IDX_W = `DSS_IDX_W,
    parameter CNT_W = `DSS_CNT_W,
    parameter TIME_W = `DSS_TIME_W,
    parameter CYC_W = `DSS_CYC_W,
    parameter TICK_CYCLES = `DSS_TICK_NS / `DSS_CLK_NS
) (
    input wire i_clk,
    input wire i_rstn,
    input wire i_tbl_we,
    input wire [IDX_W-1:0] i_tbl_addr,
    input wire i_tbl_state,
    input wire [TIME_W-1:0] i_tbl_time,
    input wire [1:0] i_mode,
    input wire [TIME_W-1:0] i_on_time,
    input wire [TIME_W-1:0] i_off_time,
    input wire [TIME_W-1:0] i_base_time,
    input wire [TIME_W-1:0] i_step_time,
    input wire [IDX_W-1:0] i_first_step,
    input wire [CNT_W-1:0] i_step_count,
    input wire [CYC_W-1:0] i_cycles,
    input wire i_infinite,
    input wire [1:0] i_end_state,
    input wire i_start,
    input wire i_stop,
    output reg o_out_en,
    output wire o_busy,
    output reg [IDX_W-1:0] o_cur_step,
    output reg o_done
);
    localparam ST_IDLE = 2'h0;
    localparam ST_FETCH = 2'h1;
    localparam ST_LOAD = 2'h2;
    localparam ST_RUN = 2'h3;
    localparam TW = 32;

    // ***********************************
    // Helpers
    // ***********************************
    function [TIME_W-1:0] sat_sub;
        input [TIME_W-1:0] a;
        input [TIME_W-1:0] b;
        begin
            sat_sub = (a > b) ? a - b : {TIME_W{1'b0}};
        end
    endfunction

    function [TIME_W-1:0] sat_add;
        input [TIME_W-1:0] a;
        input [TIME_W-1:0] b;
        reg [TIME_W:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            sat_add = s[TIME_W] ? {TIME_W{1'b1}} : s[TIME_W-1:0];
        end
    endfunction

    // ***********************************
    // Step table
    // ***********************************
    wire [TIME_W:0] rd_word;
    reg [IDX_W-1:0] rd_addr;

    dss_step_mem #(
        .AW(IDX_W),
        .DW(TIME_W + 1)
    ) u_mem (
        .i_clk(i_clk),
        .i_we(i_tbl_we),
        .i_waddr(i_tbl_addr),
        .i_wdata({i_tbl_state, i_tbl_time}),
        .i_raddr(rd_addr),
        .o_rdata(rd_word)
    );

    // ***********************************
    // Duration tick divider
    // ***********************************
    reg [TW-1:0] div_cnt;
    reg [1:0] state;
    wire tick = (div_cnt == TICK_CYCLES - 1);

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_cnt <= 32'h0;
        end else if (state != ST_RUN || tick) begin
            div_cnt <= 32'h0;
        end else begin
            div_cnt <= div_cnt + 32'h1;
        end
    end

    // ***********************************
    // Sequencer
    // ***********************************
    reg [CNT_W-1:0] steps_left;
    reg [CYC_W-1:0] cycles_left;
    reg [TIME_W-1:0] dur_left;
    reg [TIME_W-1:0] prev_dur;
    reg first_of_pass;
    reg last_state;

    assign o_busy = (state != ST_IDLE);

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ST_IDLE;
            rd_addr <= {IDX_W{1'b0}};
            o_cur_step <= {IDX_W{1'b0}};
            steps_left <= {CNT_W{1'b0}};
            cycles_left <= {CYC_W{1'b0}};
            dur_left <= {TIME_W{1'b0}};
            prev_dur <= {TIME_W{1'b0}};
            first_of_pass <= 1'b0;
            last_state <= 1'b0;
            o_out_en <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (i_start && i_step_count != {CNT_W{1'b0}} &&
                        (i_infinite || i_cycles != {CYC_W{1'b0}})) begin
                        rd_addr <= i_first_step;
                        steps_left <= i_step_count;
                        cycles_left <= (i_cycles > `DSS_CYC_MAX) ? `DSS_CYC_MAX : i_cycles;
                        first_of_pass <= 1'b1;
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    // Memory read has one cycle of latency
                    o_cur_step <= rd_addr;
                    state <= ST_LOAD;
                end
                ST_LOAD: begin
                    // apply stored state of this step
                    o_out_en <= rd_word[TIME_W];
                    last_state <= rd_word[TIME_W];
                    first_of_pass <= 1'b0;
                    case (i_mode)
                        `DSS_MODE_FIX: begin
                            dur_left <= rd_word[TIME_W] ? i_on_time : i_off_time;
                        end
                        `DSS_MODE_INCR: begin
                            dur_left <= first_of_pass ? i_base_time : sat_add(prev_dur, i_step_time);
                            prev_dur <= first_of_pass ? i_base_time : sat_add(prev_dur, i_step_time);
                        end
                        `DSS_MODE_DECL: begin
                            dur_left <= first_of_pass ? i_base_time : sat_sub(prev_dur, i_step_time);
                            prev_dur <= first_of_pass ? i_base_time : sat_sub(prev_dur, i_step_time);
                        end
                        default: begin
                            dur_left <= rd_word[TIME_W-1:0];
                        end
                    endcase
                    state <= ST_RUN;
                end
                ST_RUN: begin
                    if (dur_left == {TIME_W{1'b0}} || (tick && dur_left == {{(TIME_W-1){1'b0}}, 1'b1})) begin
                        if (steps_left != {{(CNT_W-1){1'b0}}, 1'b1}) begin
                            steps_left <= steps_left - {{(CNT_W-1){1'b0}}, 1'b1};
                            rd_addr <= rd_addr + {{(IDX_W-1){1'b0}}, 1'b1};
                            state <= ST_FETCH;
                        end else if (i_infinite ||
                                     cycles_left != {{(CYC_W-1){1'b0}}, 1'b1}) begin
                            // next pass restarts at first step
                            if (!i_infinite) begin
                                cycles_left <= cycles_left - {{(CYC_W-1){1'b0}}, 1'b1};
                            end
                            steps_left <= i_step_count;
                            rd_addr <= i_first_step;
                            first_of_pass <= 1'b1;
                            state <= ST_FETCH;
                        end else begin
                            case (i_end_state)
                                `DSS_END_OFF: o_out_en <= 1'b0;
                                `DSS_END_ON: o_out_en <= 1'b1;
                                default: o_out_en <= last_state;
                            endcase
                            o_done <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end else if (tick) begin
                        dur_left <= dur_left - {{(TIME_W-1){1'b0}}, 1'b1};
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            if (i_stop && state != ST_IDLE) begin
                state <= ST_IDLE;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/dss_power_stage.sv ----
`timescale 1ns/1ns
`default_nettype none
module dss_power_stage (
    input wire logic i_clk,
    input wire logic i_clr,
    input wire logic i_en,
    output logic [15:0] o_on_cyc,
    output logic [7:0] o_rises
);
    logic prev;
    always @(posedge i_clk) begin
        prev <= i_en;
        if (i_clr) begin
            o_on_cyc <= 16'h0000;
            o_rises <= 8'h00;
        end else begin
            o_on_cyc <= o_on_cyc + {15'h0000, i_en};
            o_rises <= o_rises + {7'h00, i_en & ~prev};
        end
    end
endmodule
`default_nettype wire

// ---- testbench/dss_sequencer_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module dss_seq_chk (
    input wire i_clk,
    input wire i_rstn,
    input wire i_start,
    input wire i_infinite,
    input wire [11:0] i_step_count,
    input wire [16:0] i_cycles,
    input wire [10:0] i_first_step,
    input wire [1:0] i_end_state,
    input wire o_out_en,
    input wire o_busy,
    input wire [10:0] o_cur_step,
    input wire o_done
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence go_s;
        i_start && !o_busy && i_step_count != 12'h000;
    endsequence
    sequence ok_s;
        go_s ##0 (i_infinite || i_cycles != 17'h00000);
    endsequence
    start_taken_a: assert property (ok_s |=> o_busy) else $error("valid start ignored");
    first_index_a: assert property (ok_s |=> ##1 o_cur_step == $past(i_first_step, 2))
        else $error("pass began at wrong step");
    zero_steps_a: assert property (i_start && !o_busy && i_step_count == 12'h000 |=> !o_busy)
        else $error("zero step count started");
    zero_reps_a: assert property (go_s ##0 (!i_infinite && i_cycles == 17'h00000) |=> !o_busy)
        else $error("zero repetitions started");
    end_off_a: assert property (o_done && i_end_state == 2'h0 |-> !o_out_en) else $error("end off");
    end_on_a: assert property (o_done && i_end_state == 2'h1 |-> o_out_en) else $error("end on");
    done_pulse_a: assert property (o_done |-> !o_busy ##1 !o_done) else $error("done pulse");
    no_end_a: assert property (o_done |-> !$past(i_infinite)) else $error("infinite run ended");
    idle_hold_a: assert property (!o_busy && !i_start |=> $stable(o_out_en))
        else $error("output moved while idle");
endmodule
bind dss_sequencer dss_seq_chk u_chk (.*);
`default_nettype wire

// ---- testbench/dss_sequencer_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "dss_regs.vh"
module dss_sequencer_bench;
    localparam int T = 4;
    logic clk = 1'h0, rstn = 1'h0, we = 1'h0, st = 1'h0, inf = 1'h0, start = 1'h0, stop = 1'h0, clr = 1'h0;
    logic [10:0] adr = '0, first = '0, cur;
    logic [15:0] tm = '0, on_t = 16'h0002, off_t = 16'h0005, base = 16'h0003, dec = 16'h0002, on_cyc;
    logic [1:0] md = '0, es = '0;
    logic [11:0] cnt = '0;
    logic [16:0] cyc = '0;
    logic out_en, busy, done;
    logic [7:0] rises;
    int num_errors = 0, total_checks = 0, tick_n = 0;
    dss_sequencer #(.TICK_CYCLES(T)) dut (.i_clk(clk), .i_rstn(rstn), .i_tbl_we(we), .i_tbl_addr(adr),
        .i_tbl_state(st), .i_tbl_time(tm), .i_mode(md), .i_on_time(on_t), .i_off_time(off_t),
        .i_base_time(base), .i_step_time(dec), .i_first_step(first), .i_step_count(cnt), .i_cycles(cyc),
        .i_infinite(inf), .i_end_state(es), .i_start(start), .i_stop(stop), .o_out_en(out_en),
        .o_busy(busy), .o_cur_step(cur), .o_done(done));
    dss_power_stage u_stage (.i_clk(clk), .i_clr(clr), .i_en(out_en), .o_on_cyc(on_cyc), .o_rises(rises));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Cut a hung run short; every test together needs well under this
    always @(posedge clk) begin
        tick_n <= tick_n + 1;
        if (tick_n == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic rng(input string n, input int lo, input int hi, input logic [31:0] g);
        total_checks++;
        if ($isunknown(g) || g < lo || g > hi) begin
            num_errors++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask
    task automatic run(input [10:0] f, input [11:0] c, input [16:0] r, input [1:0] m, input [1:0] e);
        @(posedge clk);
        first <= f;
        cnt <= c;
        cyc <= r;
        md <= m;
        es <= e;
        start <= 1'h1;
        clr <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        clr <= 1'h0;
        if (!inf) begin
            while (done !== 1'b1) @(posedge clk);
            $display("test from step %0d mode %0d ends", f, m);
        end
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        first <= 11'h003;
        cnt <= 12'h004;
        for (int j = 0; j < 4; j++) begin
            @(posedge clk);
            we <= 1'h1;
            adr <= 11'h003 + j[10:0];
            st <= ~j[0];
            tm <= 16'h0001;
        end
        @(posedge clk);
        we <= 1'h0;
        run(11'h003, 12'h004, 17'h00003, `DSS_MODE_TABLE, `DSS_END_OFF);
        chk("rises", 6, rises);
        rng("on_cycles", 6 * T, 6 * T + 30, on_cyc);
        chk("end_off", 0, out_en);
        chk("last_step", 6, cur);
        run(11'h003, 12'h004, 17'h00001, `DSS_MODE_DECL, `DSS_END_OFF);
        rng("decline_on", 3 * T, 3 * T + 10, on_cyc);
        run(11'h003, 12'h004, 17'h00001, `DSS_MODE_INCR, `DSS_END_OFF);
        rng("increase_on", 10 * T, 10 * T + 10, on_cyc);
        run(11'h003, 12'h004, 17'h00001, `DSS_MODE_FIX, `DSS_END_OFF);
        rng("uniform_on", 4 * T, 4 * T + 10, on_cyc);
        for (int i = 0; i < 4; i++) begin
            run(11'h003 + i[10:0] % 2, 12'h001, 17'h00001, `DSS_MODE_TABLE, (i > 1) ? `DSS_END_LAST : i[1:0]);
            chk("end_state", (i == 1 || i == 2), out_en);
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            cnt <= k ? 12'h004 : 12'h000;
            cyc <= k ? 17'h00000 : 17'h00001;
            start <= 1'h1;
            @(posedge clk);
            start <= 1'h0;
            repeat (2) @(posedge clk);
            chk("refused", 0, busy);
            $display("refusal test %0d ends", k);
        end
        @(posedge clk);
        inf <= 1'h1;
        run(11'h003, 12'h004, 17'h00001, `DSS_MODE_TABLE, `DSS_END_OFF);
        repeat (300) @(posedge clk);
        chk("infinite", 1, busy);
        stop <= 1'h1;
        inf <= 1'h0;
        repeat (3) @(posedge clk);
        chk("stopped", 0, busy);
        $display("infinite test ends");
        stop <= 1'h0;
        complete_run();
    end
endmodule
`default_nettype wire
